//--- hw/jbp_pkg.sv
// jbp_pkg: constants, codes and carrier types for the test access port block.
// assumes one 100 MHz system clock; the test clock arrives on a pin.
`default_nettype none
package jbp_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SIG    = 8'h08;
  localparam logic [7:0] REG_IDCODE = 8'h0C;

  // control register reset: port on, keeper off, pull-up on
  localparam logic [2:0] CTRL_RST = 3'h5;

  // erased contents of configuration and signature
  localparam logic [31:0] CFG_ERASED = 32'hFFFF_FFFF;
  localparam logic [15:0] SIG_ERASED = 16'hFFFF;

  // pin positions shared with the test port
  localparam int TDI_IDX = 3;
  localparam int TMS_IDX = 8;
  localparam int TDO_IDX = 19;
  localparam int TCK_IDX = 24;

  // instruction codes
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST   = 4'h0;
  localparam logic [3:0] IR_SAMPLE   = 4'h1;
  localparam logic [3:0] IR_IDCODE   = 4'h2;
  localparam logic [3:0] IR_HIGHZ    = 4'h3;
  localparam logic [3:0] IR_ISP_ADDR = 4'h8;
  localparam logic [3:0] IR_ISP_DATA = 4'h9;
  localparam logic [3:0] IR_ISP_ERAS = 4'hA;
  localparam logic [3:0] IR_ISP_SIG  = 4'hB;
  localparam logic [3:0] IR_ISP_FUSE = 4'hC;
  localparam logic [3:0] IR_ISP_DONE = 4'hD;
  localparam logic [3:0] IR_BYPASS   = 4'hF;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;

  // data register lengths
  localparam int DR_LEN_ID   = 32;
  localparam int DR_LEN_DATA = 32;
  localparam int DR_LEN_SIG  = 16;
  localparam int DR_LEN_BYP  = 1;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB,
    TAP_EX1_IR = 4'hC, TAP_PA_IR = 4'hD, TAP_EX2_IR = 4'hE, TAP_UP_IR  = 4'hF
  } jbp_tap_e;

  typedef struct packed {
    logic pullup_en;
    logic keeper_en;
    logic port_en;
  } jbp_cfg_s;

  typedef struct packed {
    logic       busy;
    logic       lock;
    logic       fuse;
    logic [3:0] ir;
    jbp_tap_e   tap;
  } jbp_stat_s;
endpackage
`default_nettype wire

//--- hw/jbp_top.sv
// jbp_top: boundary-scan and in-system programming port of the device.
// assumes test pins arrive asynchronously and are sampled by clock;
// registers are reached over an Avalon-MM slave with waitrequest.
// Notes on behaviour
// - with the fuse set, configuration reads give zero; signature stays readable.
// - all programming goes over the four-wire serial test port protocol.
// - test pins belong to the port; core logic keeps running internally.
// - port disabled turns the four test pins back into user I/O.
// - interrupted programming locks the device and floats all pins except the four port pins while the port is enabled.
// - keeper option holds each pin's last level during programming.
// - after reset the configuration and signature read as erased.
// - no test reset pin; power-up reset clears the controller.
// - SAMPLE/PRELOAD, EXTEST, BYPASS, IDCODE and HIGHZ supported.
// - every I/O pin and dedicated input has its own scan cell.
// - an I/O cell holds three capture stages and two update stages; an input cell one capture stage.
// - distinct cell variants: one for I/O pins, one for dedicated inputs.
// - cells chained via capture stages from data in to data out.
// - capture stages sample, shift and load updates under controller control.
// - mode-select and data-in pins offer an optional pull-up.
// - port signals share user I/O pins for both test and programming.
`default_nettype none
module jbp_top
  import jbp_pkg::*;
#(
  parameter int          NIO       = 32,
  parameter int          NIN       = 4,
  parameter int          CFG_WORDS = 16,
  parameter logic [31:0] ID_CODE   = 32'h0A5C_0001  // arbitrary value
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic [7:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [NIO-1:0]   pin_in,
  output logic      [NIO-1:0]   pin_out,
  output logic      [NIO-1:0]   pin_oe,
  input  wire logic [NIN-1:0]   ded_in,
  input  wire logic [NIO-1:0]   core_out,
  input  wire logic [NIO-1:0]   core_oe,
  output logic      [NIO-1:0]   core_pin_in,
  output logic      [NIN-1:0]   core_ded_in,
  output logic                  pin_keep,
  output logic                  pull_up_en
);
  import jbp_pkg::*;

  localparam int BSR_LEN = NIO * 3 + NIN;
  localparam int AW = $clog2(CFG_WORDS);

  jbp_cfg_s            cfg_q;
  jbp_tap_e            tap_q;
  logic [NIO-1:0]      pin_m_q;
  logic [NIN-1:0]      ded_m_q;
  logic                tck_prev_q;
  logic [IR_W-1:0]     ir_sh_q;
  logic [IR_W-1:0]     ir_q;
  logic [31:0]         dr_q;
  logic [BSR_LEN-1:0]  bsr_q;
  logic [BSR_LEN-1:0]  cap_vec;
  logic [NIO-1:0]      upd_out_q;
  logic [NIO-1:0]      upd_oe_q;
  logic [31:0]         cfg_mem_q [CFG_WORDS];
  logic [AW-1:0]       addr_q;
  logic [15:0]         sig_q;
  logic                fuse_q;
  logic                busy_q;
  logic                lock_q;
  logic                tdo_q;
  logic                tdo_oe_q;
  logic                wait_q;
  logic [NIO-1:0]      out_d;
  logic [NIO-1:0]      oe_d;
  logic                tck_s;
  logic                rise;
  logic                fall;
  logic                tms;
  logic                tdi;
  logic                bsr_sel;
  logic                bus_req;
  int                  dr_len;
  jbp_stat_s           stat;

  // pin synchronisers; second stage is the core-facing copy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_m_q     <= '0;
      core_pin_in <= '0;
      ded_m_q     <= '0;
      core_ded_in <= '0;
      tck_prev_q  <= 1'b0;
    end else if (ce) begin
      pin_m_q     <= pin_in;
      core_pin_in <= pin_m_q;
      ded_m_q     <= ded_in;
      core_ded_in <= ded_m_q;
      tck_prev_q  <= core_pin_in[TCK_IDX];
    end
  end

  assign tck_s = core_pin_in[TCK_IDX];
  assign tms   = core_pin_in[TMS_IDX];
  assign tdi   = core_pin_in[TDI_IDX];
  assign rise  = cfg_q.port_en & tck_s & ~tck_prev_q;
  assign fall  = cfg_q.port_en & ~tck_s & tck_prev_q;

  function automatic jbp_tap_e tap_next(input jbp_tap_e s, input logic m);
    unique case (s)
      TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  tap_next = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  // controller state; power-up reset only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tap_q <= TAP_RESET;
    end else if (ce && rise) begin
      tap_q <= tap_next(tap_q, tms);
    end
  end

  // instruction register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q    <= IR_IDCODE;
    end else if (ce && rise) begin
      unique case (tap_q)
        TAP_RESET:  ir_q <= IR_IDCODE;
        TAP_CAP_IR: ir_sh_q <= IR_CAPTURE;
        TAP_SH_IR:  ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
        TAP_UP_IR:  ir_q <= ir_sh_q;
        default:    ir_q <= ir_q;
      endcase
    end
  end

  assign bsr_sel = (ir_q == IR_EXTEST) || (ir_q == IR_SAMPLE);

  always_comb begin
    unique case (ir_q)
      IR_IDCODE:   dr_len = DR_LEN_ID;
      IR_ISP_DATA: dr_len = DR_LEN_DATA;
      IR_ISP_SIG:  dr_len = DR_LEN_SIG;
      IR_ISP_ADDR: dr_len = AW;
      default:     dr_len = DR_LEN_BYP;
    endcase
  end

  // non-boundary data registers share one shifter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dr_q <= '0;
    end else if (ce && rise) begin
      if (tap_q == TAP_CAP_DR) begin
        unique case (ir_q)
          IR_IDCODE:   dr_q <= ID_CODE;
          IR_ISP_DATA: dr_q <= fuse_q ? '0 : cfg_mem_q[addr_q];
          IR_ISP_SIG:  dr_q <= {16'h0000, sig_q};
          IR_ISP_ADDR: dr_q <= {{(32 - AW){1'b0}}, addr_q};
          default:     dr_q <= '0;
        endcase
      end else if (tap_q == TAP_SH_DR) begin
        dr_q             <= dr_q >> 1;
        dr_q[dr_len - 1] <= tdi;
      end
    end
  end

  // capture vector: I/O cell holds pin, core data, core enable; input cell one
  genvar gi;
  generate
    for (gi = 0; gi < NIO; gi++) begin : g_io_cell
      assign cap_vec[3*gi]     = core_pin_in[gi];
      assign cap_vec[3*gi + 1] = core_out[gi];
      assign cap_vec[3*gi + 2] = core_oe[gi];
    end
    for (gi = 0; gi < NIN; gi++) begin : g_in_cell
      assign cap_vec[3*NIO + gi] = core_ded_in[gi];
    end
  endgenerate

  // boundary chain: tdi enters at top, bit 0 feeds tdo
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bsr_q     <= '0;
      upd_out_q <= '0;
      upd_oe_q  <= '0;
    end else if (ce && rise && bsr_sel) begin
      unique case (tap_q)
        TAP_CAP_DR: bsr_q <= cap_vec;
        TAP_SH_DR:  bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]};
        TAP_UP_DR: begin
          for (int i = 0; i < NIO; i++) begin
            upd_out_q[i] <= bsr_q[3*i + 1];
            upd_oe_q[i]  <= bsr_q[3*i + 2];
          end
        end
        default: bsr_q <= bsr_q;
      endcase
    end
  end

  // programming engine
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_mem_q[i] <= CFG_ERASED;
      end
      sig_q  <= SIG_ERASED;
      fuse_q <= 1'b0;
      addr_q <= '0;
      busy_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (ce) begin
      if (busy_q && (!cfg_q.port_en || (rise && tap_q == TAP_RESET))) begin
        busy_q <= 1'b0;
        lock_q <= 1'b1;
      end else if (rise && tap_q == TAP_UP_DR) begin
        unique case (ir_q)
          IR_ISP_ADDR: addr_q <= dr_q[AW-1:0];
          IR_ISP_ERAS: begin
            for (int i = 0; i < CFG_WORDS; i++) begin
              cfg_mem_q[i] <= CFG_ERASED;
            end
            sig_q  <= SIG_ERASED;
            fuse_q <= 1'b0;
            busy_q <= 1'b1;
            lock_q <= 1'b0;
          end
          IR_ISP_DATA: if (busy_q) cfg_mem_q[addr_q] <= dr_q;
          IR_ISP_SIG:  if (busy_q) sig_q <= dr_q[15:0];
          IR_ISP_FUSE: if (busy_q) fuse_q <= 1'b1;
          IR_ISP_DONE: busy_q <= 1'b0;
          default:     addr_q <= addr_q;
        endcase
      end
    end
  end

  // test data out changes on falling test clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (ce && fall) begin
      tdo_oe_q <= (tap_q == TAP_SH_DR) || (tap_q == TAP_SH_IR);
      if (tap_q == TAP_SH_IR) begin
        tdo_q <= ir_sh_q[0];
      end else if (tap_q == TAP_SH_DR) begin
        tdo_q <= bsr_sel ? bsr_q[0] : dr_q[0];
      end
    end
  end

  // per-pin drive selection
  generate
    for (gi = 0; gi < NIO; gi++) begin : g_pin
      localparam bit IS_TAP = (gi == TDI_IDX) || (gi == TMS_IDX) ||
                              (gi == TCK_IDX) || (gi == TDO_IDX);
      localparam bit IS_TDO = (gi == TDO_IDX);
      // port pins keep serving the port while programming, so verify works
      always_comb begin
        if (IS_TAP && cfg_q.port_en) begin
          out_d[gi] = IS_TDO ? tdo_q : 1'b0;
          oe_d[gi]  = IS_TDO ? tdo_oe_q : 1'b0;
        end else if (busy_q || lock_q) begin
          out_d[gi] = pin_out[gi];
          oe_d[gi]  = 1'b0;
        end else if (ir_q == IR_HIGHZ) begin
          out_d[gi] = 1'b0;
          oe_d[gi]  = 1'b0;
        end else if (ir_q == IR_EXTEST) begin
          out_d[gi] = upd_out_q[gi];
          oe_d[gi]  = upd_oe_q[gi];
        end else begin
          out_d[gi] = core_out[gi];
          oe_d[gi]  = core_oe[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pin_keep   <= 1'b0;
      pull_up_en <= 1'b0;
    end else if (ce) begin
      pin_out    <= out_d;
      pin_oe     <= oe_d;
      pin_keep   <= cfg_q.keeper_en & (busy_q | lock_q);
      pull_up_en <= cfg_q.pullup_en & cfg_q.port_en;
    end
  end

  // Avalon-MM slave: one wait cycle, then the answer
  assign bus_req = avs_read | avs_write;
  assign stat    = '{busy: busy_q, lock: lock_q, fuse: fuse_q, ir: ir_q, tap: tap_q};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_q       <= 1'b1;
      avs_readdata <= '0;
    end else if (ce) begin
      wait_q <= ~(bus_req & wait_q);
      if (avs_read && wait_q) begin
        unique case (avs_address)
          REG_CTRL:   avs_readdata <= {29'h0000_0000, cfg_q};
          REG_STATUS: avs_readdata <= {21'h00_0000, stat};
          REG_SIG:    avs_readdata <= {16'h0000, sig_q};
          REG_IDCODE: avs_readdata <= ID_CODE;
          default:    avs_readdata <= '0;
        endcase
      end
    end
  end

  assign avs_waitrequest = wait_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= CTRL_RST;
    end else if (ce && avs_write && !wait_q && avs_address == REG_CTRL) begin
      cfg_q <= avs_writedata[2:0];
    end
  end
endmodule // jbp_top
`default_nettype wire

//--- tb/jbp_top_properties.sv
// jbp_top_properties: port checks of the test access port block.
// assumes binding into jbp_top; sees its ports only.
`default_nettype none
module jbp_top_properties
  import jbp_pkg::*;
#(
  parameter int          NIO     = 32,
  parameter int          NIN     = 4,
  parameter logic [31:0] ID_CODE = 32'h0A5C_0001  // arbitrary value
) (
  input wire logic           clock,
  input wire logic           nrst,
  input wire logic [7:0]     avs_address,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_readdata,
  input wire logic           avs_waitrequest,
  input wire logic [NIO-1:0] pin_in,
  input wire logic [NIO-1:0] pin_out,
  input wire logic [NIO-1:0] pin_oe,
  input wire logic [NIN-1:0] ded_in,
  input wire logic [NIO-1:0] core_pin_in,
  input wire logic [NIN-1:0] core_ded_in,
  input wire logic           pin_keep,
  input wire logic           pull_up_en
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // the four port pins stay with the port during programming
  localparam logic [NIO-1:0] PORT_PINS = (NIO'(1) << TDI_IDX) | (NIO'(1) << TMS_IDX) |
                                         (NIO'(1) << TDO_IDX) | (NIO'(1) << TCK_IDX);

  AST_WAIT_ANSWER: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  AST_PWRUP_QUIET: assert property ($rose(nrst) |-> pin_oe == '0 && !pin_keep)
    else $error("pins active after reset");
  AST_PULLUP_ON: assert property ($rose(nrst) |-> ##[1:2] pull_up_en)
    else $error("pull-up not on after reset");
  AST_KEEP_FLOAT: assert property (pin_keep && $past(pin_keep) |-> (pin_oe & ~PORT_PINS) == '0)
    else $error("pin driven while programming");
  AST_TDO_FALL: assert property (pin_oe[TDO_IDX] && $past(pin_oe[TDO_IDX])
    && $changed(pin_out[TDO_IDX]) |-> !pin_in[TCK_IDX] && !$past(pin_in[TCK_IDX], 3))
    else $error("data out moved off falling test clock");
  AST_CORE_SYNC: assert property (($stable(pin_in) && $stable(ded_in)) [*4]
    |-> core_pin_in == pin_in && core_ded_in == ded_in)
    else $error("core inputs do not follow pins");
  AST_ID_READ: assert property (!avs_waitrequest && avs_read
    && avs_address == REG_IDCODE |-> avs_readdata == ID_CODE)
    else $error("identity read wrong");

  cover property (!avs_waitrequest && avs_read);
  cover property (pin_keep);
  cover property (pin_oe[TDO_IDX]);
endmodule  // jbp_top_properties

bind jbp_top jbp_top_properties #(.NIO(NIO), .NIN(NIN), .ID_CODE(ID_CODE)) u_props (
  .clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ded_in(ded_in),
  .core_pin_in(core_pin_in), .core_ded_in(core_ded_in), .pin_keep(pin_keep),
  .pull_up_en(pull_up_en)
);
`default_nettype wire

//--- tb/jbp_jtag_master.sv
// jbp_jtag_master: behavioural test master on the four test pins.
// assumes its tasks are entered just after a rising clock edge.
`default_nettype none
module jbp_jtag_master (
  input  wire logic clock,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  timeunit 1ns;
  timeprecision 1ps;

  // test clock rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one 160 ns test clock, data out taken before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clock);
    o = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge clock);
    tck <= 1'b0;
  endtask

  task automatic home();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask

  // idle to idle scan, lsb first
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule  // jbp_jtag_master
`default_nettype wire

//--- tb/tb_jbp_top.sv
// tb_jbp_top: self-checking bench of the test access port block.
// assumes the test master model and the bound checker.
`default_nettype none
module tb_jbp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import jbp_pkg::*;

  localparam logic [31:0] ID = 32'h0A5C_0001;  // arbitrary value
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } jbp_row_s;
  localparam jbp_row_s ROWS [10] = '{
    '{1'b0, REG_CTRL, 32'h0, 32'h5}, '{1'b0, REG_STATUS, 32'h0, 32'h20},
    '{1'b0, REG_SIG, 32'h0, 32'hFFFF}, '{1'b0, REG_IDCODE, 32'h0, ID},
    '{1'b1, REG_IDCODE, 32'h0, 32'h0}, '{1'b0, REG_IDCODE, 32'h0, ID},
    '{1'b1, 8'h10, 32'h1234, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h0},
    '{1'b1, REG_CTRL, 32'h7, 32'h0}, '{1'b0, REG_CTRL, 32'h0, 32'h7}};

  logic        clock, nrst, ce, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, bq, pad_q, ext;
  logic [31:0] pin_in, pin_out, pin_oe, core_out, core_oe, core_pin_in;
  logic [3:0]  ded_in, core_ded_in;
  logic        pin_keep, pull_up_en, tck, tms, tdi;
  logic [127:0] sq;
  int          num_errors, num_checks;

  always #5 clock = ~clock;
  always_comb begin
    ext = pad_q;
    ext[TDI_IDX] = tdi;
    ext[TMS_IDX] = tms;
    ext[TCK_IDX] = tck;
    ext[TDO_IDX] = ~pin_out[TDO_IDX];
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  jbp_top #(.ID_CODE(ID)) dut (
    .clock(clock), .nrst(nrst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .ded_in(ded_in), .core_out(core_out),
    .core_oe(core_oe), .core_pin_in(core_pin_in), .core_ded_in(core_ded_in),
    .pin_keep(pin_keep), .pull_up_en(pull_up_en));
  jbp_jtag_master m (.clock(clock), .tdo(pin_in[TDO_IDX]), .tck(tck), .tms(tms), .tdi(tdi));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_of_test();
  end

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    pad_q = 32'h1;
    ded_in = 4'hA;
    core_out = 32'h0008_0000;
    core_oe = 32'h00F0_0000;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    foreach (ROWS[i]) begin
      bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, bq);
      if (!ROWS[i].w) chk(bq, ROWS[i].e);
    end
    $display("register table done");
    m.home();
    m.scan(1'b0, 32, '0, sq);
    chk(sq[31:0], ID);
    m.scan(1'b1, 4, IR_BYPASS, sq);
    chk(sq[3:0], IR_CAPTURE);
    m.scan(1'b0, 8, 8'hA5, sq);
    chk(sq[7:0], 8'h4A);
    chk(pin_oe[23:20], 4'hF);
    m.scan(1'b1, 4, IR_SAMPLE, sq);
    m.scan(1'b0, 100, 128'h6, sq);
    chk({sq[99:96], sq[0]}, 5'h15);
    chk(sq[62:60], 3'b100);
    m.scan(1'b1, 4, IR_EXTEST, sq);
    chk({pin_oe[23:20], pin_oe[0], pin_out[0]}, 6'h03);
    m.scan(1'b1, 4, IR_HIGHZ, sq);
    chk(pin_oe, 32'h0);
    m.home();
    $display("scan instructions done");
    bus(1'b1, REG_CTRL, 32'h6, bq);
    core_oe <= 32'h0008_0000;
    repeat (4) @(posedge clock);
    chk({pin_oe[TDO_IDX], pin_out[TDO_IDX]}, 2'b11);
    chk(pull_up_en, 1'b0);
    core_oe <= 32'h00F0_0000;
    bus(1'b1, REG_CTRL, 32'h7, bq);
    $display("user pin mode done");
    m.scan(1'b1, 4, IR_ISP_ERAS, sq);
    m.scan(1'b0, 1, '0, sq);
    bus(1'b0, REG_STATUS, 32'h0, bq);
    chk(bq[10:8], 3'b100);
    chk({pin_keep, |pin_oe}, 2'b10);
    m.scan(1'b1, 4, IR_ISP_ADDR, sq);
    m.scan(1'b0, 4, 128'h5, sq);
    chk(sq[3:0], 4'h0);
    m.scan(1'b1, 4, IR_ISP_DATA, sq);
    m.scan(1'b0, 32, 128'h1234_5678, sq);
    chk(sq[31:0], CFG_ERASED);
    m.scan(1'b0, 32, '1, sq);
    chk(sq[31:0], 32'h1234_5678);
    m.scan(1'b1, 4, IR_ISP_SIG, sq);
    m.scan(1'b0, 16, 128'h5A3C, sq);
    chk(sq[15:0], SIG_ERASED);
    m.scan(1'b1, 4, IR_ISP_FUSE, sq);
    m.scan(1'b0, 1, 128'h1, sq);
    m.scan(1'b1, 4, IR_ISP_DATA, sq);
    m.scan(1'b0, 32, '1, sq);
    chk(sq[31:0], 32'h0);
    m.scan(1'b1, 4, IR_ISP_SIG, sq);
    m.scan(1'b0, 16, 128'h5A3C, sq);
    chk(sq[15:0], 16'h5A3C);
    m.home();
    bus(1'b0, REG_STATUS, 32'h0, bq);
    chk(bq[10:8], 3'b011);
    chk({pin_keep, |pin_oe}, 2'b10);
    bus(1'b0, REG_SIG, 32'h0, bq);
    chk(bq, 32'h5A3C);
    $display("programming done");
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0, bq);
    chk(bq, 32'h20);
    m.home();
    m.scan(1'b1, 4, IR_ISP_ERAS, sq);
    m.scan(1'b0, 1, '0, sq);
    m.scan(1'b1, 4, IR_ISP_DONE, sq);
    m.scan(1'b0, 1, '0, sq);
    m.home();
    bus(1'b0, REG_STATUS, 32'h0, bq);
    chk(bq[10:8], 3'b000);
    $display("second reset done");
    end_of_test();
  end
endmodule  // tb_jbp_top
`default_nettype wire
